// File: hdl/dog_presc_if.sv
// Link between the watchdog core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface dog_presc_if;
    logic       src_sel;
    logic [2:0] tap;
    logic       run;
    logic       clr;
    logic       tick;
    logic       src_tick;
    modport core  (output src_sel, output tap, output run, output clr, input tick, input src_tick);
    modport presc (input src_sel, input tap, input run, input clr, output tick, output src_tick);
endinterface
`default_nettype wire

// File: hdl/dog_prescaler.sv
// Prescaler with clock source selection and tap select
`timescale 1ns/1ps
`default_nettype none
module dog_prescaler
    import dog_timer_pkg::*;
(
    // Clock and power-on reset
    input  wire logic   core_clk,
    input  wire logic   nrst,
    // Watchdog oscillator pin
    input  wire logic   wdosc_in,
    // Core side
    dog_presc_if.presc  pif
);
    typedef struct packed {
        logic [2:0]         osc_sync;
        logic [1:0]         sel_pipe;
        logic [PRESC_W-1:0] presc;
        logic               tick;
        logic               src_tick;
    } presc_t;

    localparam presc_t PRESC_RST = '0;

    presc_t              st_ff;
    presc_t              nxt_st;
    logic [PRESC_W-1:0]  tap_mask;
    logic [3:0]          tap_idx;

    assign tap_idx = 4'(TAP_BASE) + {1'b0, pif.tap};

    // Division by two to the power of tap index plus one
    genvar gi;
    generate
        for (gi = 0; gi < PRESC_W; gi++) begin : g_mask
            assign tap_mask[gi] = (4'(gi) <= tap_idx); // R22
        end
    endgenerate

    always_comb begin
        logic src_en;
        src_en = 1'b0;
        nxt_st = st_ff;
        nxt_st.osc_sync = {st_ff.osc_sync[1:0], wdosc_in};
        // Selection settles two cycles late, glitch-free switching
        nxt_st.sel_pipe = {st_ff.sel_pipe[0], pif.src_sel}; // R15
        src_en = st_ff.sel_pipe[1] ? (st_ff.osc_sync[1] & ~st_ff.osc_sync[2]) : 1'b1; // R14
        nxt_st.src_tick = src_en;
        nxt_st.tick = 1'b0;
        if (pif.clr) begin
            nxt_st.presc = '0;
        end else if (pif.run && src_en) begin
            nxt_st.presc = st_ff.presc + 1'b1; // R13
            nxt_st.tick = &(st_ff.presc | ~tap_mask); // R13
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= PRESC_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pif.tick     = st_ff.tick;
    assign pif.src_tick = st_ff.src_tick;

    property p_switch_late;
        @(posedge core_clk) disable iff (!nrst)
        $changed(pif.src_sel) |-> st_ff.sel_pipe[0] != pif.src_sel ##2 st_ff.sel_pipe[1] == $past(pif.src_sel, 2);
    endproperty
    a_switch_late: assert property (p_switch_late) else $error("source switched without delay"); // R15
endmodule
`default_nettype wire

// File: hdl/dog_timer_core.sv
// Watchdog timer core: feed sequencing, down counter, reset generation
`timescale 1ns/1ps
`default_nettype none
module dog_timer_core
    import dog_timer_pkg::*;
(
    // Clock and power-on reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Configuration
    input  wire logic [7:0] user_config_byte,
    input  wire logic [7:0] interrupt_enable_reg,
    // Software writes
    input  wire logic       ctrl_wr,
    input  wire logic       reload_wr,
    input  wire logic       feed_first_wr,
    input  wire logic       feed_second_wr,
    input  wire logic       other_wr,
    input  wire logic [7:0] wr_data,
    // Oscillator and power state
    input  wire logic       wdosc_in,
    input  wire logic       power_down,
    input  wire logic       osc_stable,
    // Status and reset
    output logic            wd_reset,
    output logic            timer_irq,
    output logic            timeout_flag,
    output logic [7:0]      count_value,
    output logic [7:0]      ctrl_readback,
    output logic            cpu_run,
    output logic            osc_start_req
);
    typedef struct packed {
        feed_state_t state;
        logic [7:0]  ctrl_reg;
        logic [7:0]  reload_reg;
        logic [7:0]  shadow_ctrl;
        logic [7:0]  count;
        logic [7:0]  ctrl_rd;
        logic        flag;
        logic        ctrl_once;
        logic        reload_once;
        logic        wd_reset;
        logic        irq;
        logic        cpu_run;
        logic        osc_start;
        logic        pd_seen;
        logic [1:0]  hold_cnt;
        logic [1:0]  stab_sync;
    } core_t;

    localparam core_t CORE_RST = '{
        state:       ST_IDLE,
        ctrl_reg:    CTRL_RST_VAL,
        reload_reg:  RELOAD_RST_VAL,
        shadow_ctrl: CTRL_RST_VAL,
        count:       COUNT_RST_VAL,
        ctrl_rd:     CTRL_RST_VAL,
        flag:        1'b0,
        ctrl_once:   1'b0,
        reload_once: 1'b0,
        wd_reset:    1'b0,
        irq:         1'b0,
        cpu_run:     1'b1,
        osc_start:   1'b0,
        pd_seen:     1'b0,
        hold_cnt:    2'h0,
        stab_sync:   2'h0
    };

    core_t        st_ff;
    core_t        nxt_st;
    logic         reset_en;
    logic         safety;
    logic         eff_run;
    logic         eff_sel;
    logic         any_wr;
    logic         feed_ok;
    logic         feed_bad;
    logic         underflow;

    dog_presc_if pif ();

    dog_prescaler u_presc (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wdosc_in (wdosc_in),
        .pif      (pif)
    );

    assign reset_en = user_config_byte[CFG_RESET_EN_BIT]; // R3
    assign safety   = reset_en & user_config_byte[CFG_SAFETY_BIT]; // R8
    assign eff_run  = safety | st_ff.shadow_ctrl[CTRL_RUN_BIT]; // R5 R12
    assign eff_sel  = safety | st_ff.shadow_ctrl[CTRL_SEL_BIT]; // R9 R10
    assign any_wr   = ctrl_wr | reload_wr | feed_first_wr | feed_second_wr | other_wr;
    assign underflow = pif.tick && eff_run && st_ff.state != ST_RST && st_ff.count == 8'h00;

    assign pif.src_sel = eff_sel;
    assign pif.tap     = st_ff.shadow_ctrl[CTRL_TAP_LSB +: 3]; // R22
    assign pif.run     = eff_run && st_ff.state != ST_RST;
    assign pif.clr     = feed_ok || st_ff.state == ST_RST;

    // Feed sequence decoding
    always_comb begin
        feed_ok  = 1'b0;
        feed_bad = 1'b0;
        unique case (st_ff.state)
            ST_IDLE: begin
                feed_bad = (feed_first_wr && wr_data != FEED_FIRST_KEY) || feed_second_wr;
            end
            ST_ARMED: begin
                // Any write but the first feed byte breaks the pending feed
                feed_bad = feed_first_wr ? (wr_data != FEED_FIRST_KEY) : any_wr; // R6
            end
            ST_HALF: begin
                feed_ok  = feed_second_wr && wr_data == FEED_SECOND_KEY; // R18
                feed_bad = feed_second_wr ? (wr_data != FEED_SECOND_KEY) : any_wr; // R18
            end
            ST_RST: begin
                feed_ok  = 1'b0;
                feed_bad = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.stab_sync = {st_ff.stab_sync[0], osc_stable};

        // Software copies, locked after one write under safety
        if (ctrl_wr && !(safety && st_ff.ctrl_once)) begin // R11
            nxt_st.ctrl_reg = wr_data;
            nxt_st.ctrl_once = 1'b1;
            if (!wr_data[CTRL_FLAG_BIT]) begin
                nxt_st.flag = 1'b0;
            end
        end
        if (reload_wr && !(safety && st_ff.reload_once)) begin // R11
            nxt_st.reload_reg = wr_data;
            nxt_st.reload_once = 1'b1;
        end

        // Timer mode takes control straight through
        if (!reset_en) begin
            nxt_st.shadow_ctrl = st_ff.ctrl_reg; // R21
        end

        unique case (st_ff.state)
            ST_IDLE: begin
                if (feed_first_wr && !feed_bad) begin
                    nxt_st.state = ST_HALF;
                end else if ((ctrl_wr || reload_wr) && reset_en) begin
                    nxt_st.state = ST_ARMED; // R6
                end
            end
            ST_ARMED: begin
                if (feed_first_wr && !feed_bad) begin
                    nxt_st.state = ST_HALF;
                end
            end
            ST_HALF: begin
                if (feed_ok) begin
                    nxt_st.state = ST_IDLE;
                end
            end
            ST_RST: begin
                if (pif.src_tick) begin
                    nxt_st.hold_cnt = st_ff.hold_cnt + 2'h1;
                end
                // Held over whole cycles of the selected watchdog clock
                if (pif.src_tick && st_ff.hold_cnt == RST_HOLD_TICKS - 2'h1) begin // R16
                    nxt_st.state = ST_IDLE;
                    nxt_st.wd_reset = 1'b0;
                    nxt_st.ctrl_reg[CTRL_RUN_BIT] = 1'b1; // R4
                    nxt_st.shadow_ctrl[CTRL_RUN_BIT] = 1'b1; // R5
                    nxt_st.osc_start = st_ff.pd_seen; // R17
                    nxt_st.cpu_run = !st_ff.pd_seen; // R17
                end
            end
        endcase

        if (feed_ok) begin
            nxt_st.count = st_ff.reload_reg; // R23
            if (reset_en) begin
                nxt_st.shadow_ctrl = st_ff.ctrl_reg; // R6
                nxt_st.flag = 1'b0; // R23
            end
        end else if (pif.tick && eff_run && st_ff.state != ST_RST) begin
            nxt_st.count = st_ff.count - 8'h01; // R13
        end

        // Waiting for the oscillator after a reset out of power-down
        if (st_ff.osc_start && st_ff.stab_sync[1]) begin
            nxt_st.osc_start = 1'b0;
            nxt_st.cpu_run = 1'b1; // R17
        end

        // Set wins over any clear in the same cycle
        if (underflow) begin
            nxt_st.flag = 1'b1; // R20
        end

        // Reset sources, gated by the enable bit
        if (reset_en && (underflow || feed_bad) && st_ff.state != ST_RST) begin // R1 R19
            nxt_st.state = ST_RST;
            nxt_st.wd_reset = 1'b1;
            nxt_st.hold_cnt = 2'h0;
            nxt_st.cpu_run = 1'b0;
            nxt_st.osc_start = 1'b0;
            nxt_st.pd_seen = power_down;
        end else if (!reset_en && feed_bad) begin
            nxt_st.state = ST_IDLE; // R8
        end

        nxt_st.irq = nxt_st.flag && !reset_en && interrupt_enable_reg[IRQ_EN_BIT]; // R7
        nxt_st.ctrl_rd = {nxt_st.ctrl_reg[7:5], 2'b00, nxt_st.ctrl_reg[CTRL_RUN_BIT] | safety,
                          nxt_st.flag, nxt_st.ctrl_reg[CTRL_SEL_BIT] | safety};
    end

    // Only the power-on reset clears this state
    always_ff @(posedge core_clk or negedge nrst) begin // R2
        if (!nrst) begin
            st_ff <= CORE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wd_reset      = st_ff.wd_reset;
    assign timer_irq     = st_ff.irq;
    assign timeout_flag  = st_ff.flag;
    assign count_value   = st_ff.count;
    assign ctrl_readback = st_ff.ctrl_rd;
    assign cpu_run       = st_ff.cpu_run;
    assign osc_start_req = st_ff.osc_start;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_underflow_reset;
        underflow && reset_en |=> wd_reset && st_ff.state == ST_RST;
    endproperty
    a_underflow_reset: assert property (p_underflow_reset) else $error("no reset on underflow"); // R1

    property p_flag_set;
        underflow |=> timeout_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on underflow"); // R20

    property p_bad_feed;
        reset_en && feed_first_wr && wr_data != FEED_FIRST_KEY && st_ff.state != ST_RST |=> wd_reset;
    endproperty
    a_bad_feed: assert property (p_bad_feed) else $error("bad feed did not reset"); // R19

    property p_no_reset_timer;
        $rose(wd_reset) |-> $past(reset_en);
    endproperty
    a_no_reset_timer: assert property (p_no_reset_timer) else $error("reset in timer mode"); // R8

    property p_reset_hold;
        $rose(wd_reset) |-> wd_reset[*2];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset pulse too short"); // R16

    property p_safety_sel;
        safety |-> pif.src_sel && (pif.run || st_ff.state == ST_RST);
    endproperty
    a_safety_sel: assert property (p_safety_sel) else $error("safety did not force source or run"); // R10

    property p_safety_lock;
        safety && st_ff.ctrl_once && ctrl_wr |=> st_ff.ctrl_reg == $past(st_ff.ctrl_reg);
    endproperty
    a_safety_lock: assert property (p_safety_lock) else $error("locked control was written"); // R11

    property p_feed_load;
        feed_ok |=> count_value == $past(st_ff.reload_reg) && st_ff.state != ST_HALF;
    endproperty
    a_feed_load: assert property (p_feed_load) else $error("feed did not reload counter"); // R23

    property p_timer_copy;
        !reset_en && ctrl_wr && !wd_reset ##1 !reset_en |=> st_ff.shadow_ctrl == $past(st_ff.ctrl_reg);
    endproperty
    a_timer_copy: assert property (p_timer_copy) else $error("timer mode control not copied"); // R21

    property p_run_after_reset;
        $fell(wd_reset) |-> st_ff.ctrl_reg[CTRL_RUN_BIT] && eff_run;
    endproperty
    a_run_after_reset: assert property (p_run_after_reset) else $error("counter stopped after reset"); // R4

    property p_osc_restart;
        $fell(wd_reset) |-> cpu_run != osc_start_req;
    endproperty
    a_osc_restart: assert property (p_osc_restart) else $error("restart path not taken"); // R17

    property p_ctrl_waits_feed;
        reset_en && ctrl_wr && !feed_ok && st_ff.state != ST_RST |=> st_ff.shadow_ctrl == $past(st_ff.shadow_ctrl);
    endproperty
    a_ctrl_waits_feed: assert property (p_ctrl_waits_feed) else $error("control used before feed"); // R6

    c_feed_done:    cover property (feed_ok);
    c_wd_reset:     cover property (underflow && reset_en);
    c_timer_irq:    cover property ($rose(timer_irq));
    c_pd_restart:   cover property ($fell(osc_start_req) && cpu_run);
endmodule
`default_nettype wire

// File: hdl/dog_timer_pkg.sv
// Shared constants and types of the watchdog timer core
// Summary of operation
// R1 - Underflow with reset enabled resets system
// R2 - Only power-on reset reinitialises watchdog logic
// R3 - Config bit 7 enables reset on underflow
// R4 - Counter runs after any reset
// R5 - Control bit 2 runs counter, resets set
// R6 - Watchdog mode: writes need feed before use
// R7 - Timer mode underflow may raise interrupt
// R8 - Enable clear: no reset, safety ignored
// R9 - Enable only: software picks clock source
// R10 - Both set: clock select forced to oscillator
// R11 - Both set: control, reload written once
// R12 - Both set: run control held at one
// R13 - 13-bit prescaler tap decrements 8-bit counter
// R14 - Prescaler clocked by peripheral or oscillator
// R15 - Clock source switch takes effect later
// R16 - Watchdog reset lasts one watchdog clock; the core holds it for RST_HOLD_TICKS (two) ticks of the selected source
// R17 - Restart at once or after oscillator stable
// R18 - Software feeds A5 then 5A, no writes between
// R19 - Incorrect feed resets immediately
// R20 - Underflow sets timeout flag
// R21 - Timer mode copies control every cycle
// R22 - Tap field selects power-of-two division
// R23 - Feed reloads counter, clears flag in watchdog mode
package dog_timer_pkg;
    localparam int            PRESC_W        = 13;
    localparam int            TAP_BASE       = 5;
    localparam logic [7:0]    FEED_FIRST_KEY = 8'hA5;
    localparam logic [7:0]    FEED_SECOND_KEY = 8'h5A;
    localparam int            CFG_RESET_EN_BIT = 7;
    localparam int            CFG_SAFETY_BIT = 4;
    localparam int            IRQ_EN_BIT     = 6;
    localparam int            CTRL_TAP_LSB   = 5;
    localparam int            CTRL_RUN_BIT   = 2;
    localparam int            CTRL_FLAG_BIT  = 1;
    localparam int            CTRL_SEL_BIT   = 0;
    localparam logic [7:0]    CTRL_RST_VAL   = 8'hE5;
    localparam logic [7:0]    RELOAD_RST_VAL = 8'hFF;
    localparam logic [7:0]    COUNT_RST_VAL  = 8'hFF;
    localparam logic [1:0]    RST_HOLD_TICKS = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ARMED = 2'h1,
        ST_HALF  = 2'h3,
        ST_RST   = 2'h2
    } feed_state_t;
endpackage

// File: verification/dog_timer_core_tb_top.sv
// Self-checking testbench of the watchdog timer core
`timescale 1ns/1ps
`default_nettype none
module dog_timer_core_tb_top
    import dog_timer_pkg::*;
;
    logic       core_clk;
    logic       nrst;
    logic [7:0] user_config_byte;
    logic [7:0] interrupt_enable_reg;
    logic       ctrl_wr;
    logic       reload_wr;
    logic       feed_first_wr;
    logic       feed_second_wr;
    logic       other_wr;
    logic [7:0] wr_data;
    logic       wdosc_in;
    logic       power_down;
    logic       osc_stable;
    logic       wd_reset;
    logic       timer_irq;
    logic       timeout_flag;
    logic [7:0] count_value;
    logic [7:0] ctrl_readback;
    logic       cpu_run;
    logic       osc_start_req;
    logic [1:0] osc_div;
    int         error_cnt;
    int         n_tests;
    int         cyc;
    int         n;
    logic [7:0] held;

    dog_timer_core dut_u (
        .core_clk             (core_clk),
        .nrst                 (nrst),
        .user_config_byte     (user_config_byte),
        .interrupt_enable_reg (interrupt_enable_reg),
        .ctrl_wr              (ctrl_wr),
        .reload_wr            (reload_wr),
        .feed_first_wr        (feed_first_wr),
        .feed_second_wr       (feed_second_wr),
        .other_wr             (other_wr),
        .wr_data              (wr_data),
        .wdosc_in             (wdosc_in),
        .power_down           (power_down),
        .osc_stable           (osc_stable),
        .wd_reset             (wd_reset),
        .timer_irq            (timer_irq),
        .timeout_flag         (timeout_flag),
        .count_value          (count_value),
        .ctrl_readback        (ctrl_readback),
        .cpu_run              (cpu_run),
        .osc_start_req        (osc_start_req)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Oscillator at one quarter of the core clock, free running
    always @(posedge core_clk) begin
        osc_div  <= osc_div + 2'h1;
        wdosc_in <= osc_div[1];
    end

    // Hang guard: all tests need far fewer cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic rst(input logic [7:0] cfg);
        @(posedge core_clk);
        user_config_byte <= cfg;
        nrst             <= 1'b0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        tick();
    endtask

    // One write pulse; k picks the target register
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge core_clk);
        wr_data <= d;
        case (k)
            0: ctrl_wr <= 1'b1;
            1: reload_wr <= 1'b1;
            2: feed_first_wr <= 1'b1;
            3: feed_second_wr <= 1'b1;
            default: other_wr <= 1'b1;
        endcase
        @(posedge core_clk);
        {ctrl_wr, reload_wr, feed_first_wr, feed_second_wr, other_wr} <= 5'h00;
    endtask

    // Gap of idle cycles between halves, as reads would leave
    task automatic feed(input int gap);
        wr(2, FEED_FIRST_KEY);
        repeat (gap) tick();
        wr(3, FEED_SECOND_KEY);
        tick();
    endtask

    task automatic wait_rst(input logic lvl, input int max);
        n = 0;
        while (wd_reset !== lvl && n < max) begin
            tick();
            n++;
        end
        chk(wd_reset, lvl, "wd_reset wait");
    endtask

    task automatic t_reset();
        rst(8'h00);
        chk(count_value, COUNT_RST_VAL, "count after reset");
        chk(ctrl_readback, 8'hE5, "ctrl after reset");
        chk(cpu_run, 1'b1, "cpu runs");
        chk({wd_reset, timeout_flag, timer_irq, osc_start_req}, 8'h00, "flags after reset");
        $display("test reset done");
    endtask

    task automatic t_timer();
        rst(8'h00);
        wr(1, 8'h02);
        wr(0, 8'h04);
        tick();
        chk(ctrl_readback, 8'h04, "timer ctrl copy");
        feed(0);
        chk(count_value, 8'h02, "reload on feed");
        n = 0;
        while (count_value === 8'h02 && n < 200) begin
            tick();
            n++;
        end
        chk(n >= 60 && n <= 70, 1'b1, "tap 0 tick period");
        n = 0;
        while (timeout_flag !== 1'b1 && n < 400) begin
            tick();
            n++;
        end
        chk(timeout_flag, 1'b1, "underflow flag");
        chk(count_value, 8'hFF, "timer wraps");
        tick();
        chk(timer_irq, 1'b1, "timer irq");
        chk(wd_reset, 1'b0, "no reset in timer mode");
        interrupt_enable_reg <= 8'h00;
        tick();
        tick();
        chk(timer_irq, 1'b0, "irq masked");
        interrupt_enable_reg <= 8'h40;
        wr(0, 8'h04);
        tick();
        tick();
        chk(timeout_flag, 1'b0, "flag cleared by write");
        wr(0, 8'h00);
        repeat (3) tick();
        held = count_value;
        repeat (150) tick();
        chk(count_value, held, "stopped counter");
        wr(2, 8'h11);
        wr(3, FEED_SECOND_KEY);
        tick();
        chk(wd_reset, 1'b0, "bad feed ignored in timer mode");
        $display("test timer done");
    endtask

    task automatic t_wdog();
        rst(8'h80);
        wr(1, 8'h03);
        feed(4);
        wr(0, 8'h04);
        feed(0);
        chk(wd_reset, 1'b0, "good feeds");
        chk(ctrl_readback, 8'h04, "peripheral clock chosen");
        chk(count_value, 8'h03, "reload on feed");
        wait_rst(1'b1, 400);
        chk(timeout_flag, 1'b1, "flag on underflow");
        chk(cpu_run, 1'b0, "cpu held in reset");
        wait_rst(1'b0, 50);
        chk(n >= 2, 1'b1, "reset length");
        tick();
        chk(cpu_run, 1'b1, "cpu restarts");
        chk(ctrl_readback, 8'h06, "state kept over own reset");
        feed(0);
        chk(timeout_flag, 1'b0, "feed clears flag");
        wr(2, 8'h3C);
        #1;
        chk(wd_reset, 1'b1, "wrong feed byte");
        wait_rst(1'b0, 50);
        wr(0, 8'h04);
        wr(4, 8'h00);
        #1;
        chk(wd_reset, 1'b1, "write not followed by feed");
        wait_rst(1'b0, 50);
        $display("test watchdog done");
    endtask

    task automatic t_safety();
        rst(8'h90);
        chk(ctrl_readback, 8'hE5, "safety reset value");
        wr(0, 8'h00);
        feed(0);
        chk(ctrl_readback, 8'h05, "run and oscillator forced");
        wr(1, 8'h10);
        feed(0);
        chk(count_value, 8'h10, "first reload accepted");
        wr(0, 8'hE0);
        feed(0);
        wr(1, 8'h20);
        feed(0);
        chk(ctrl_readback, 8'h05, "second ctrl write ignored");
        chk(count_value, 8'h10, "second reload ignored");
        // Tap 0 on the oscillator: 64 oscillator ticks of 4 cycles each
        n = 0;
        while (count_value === 8'h10 && n < 400) begin
            tick();
            n++;
        end
        chk(n >= 250 && n <= 260, 1'b1, "oscillator tick period");
        $display("test safety done");
    endtask

    task automatic t_pdown();
        rst(8'h80);
        power_down <= 1'b1;
        osc_stable <= 1'b0;
        wr(1, 8'h00);
        feed(0);
        wr(0, 8'h04);
        feed(0);
        wait_rst(1'b1, 300);
        wait_rst(1'b0, 50);
        tick();
        chk(osc_start_req, 1'b1, "oscillator start");
        chk(cpu_run, 1'b0, "wait for oscillator");
        osc_stable <= 1'b1;
        repeat (6) tick();
        chk(cpu_run, 1'b1, "resume when stable");
        power_down <= 1'b0;
        $display("test power down done");
    endtask

    initial begin
        nrst                 = 1'b0;
        user_config_byte     = 8'h00;
        interrupt_enable_reg = 8'h40;
        {ctrl_wr, reload_wr, feed_first_wr, feed_second_wr, other_wr} = 5'h00;
        wr_data              = 8'h00;
        wdosc_in             = 1'b0;
        osc_div              = 2'h0;
        power_down           = 1'b0;
        osc_stable           = 1'b1;
        error_cnt            = 0;
        n_tests              = 0;
        cyc                  = 0;
        t_reset();
        t_timer();
        t_wdog();
        t_safety();
        t_pdown();
        results();
    end
endmodule
`default_nettype wire
